// [common/drv_diag_pkg.sv]
// shared constants and types for the octal driver fault diagnosis block
package drv_diag_pkg;
  localparam int NCH       = 8;
  localparam int CODE_W    = 2;
  localparam int WORD_W    = NCH * CODE_W;
  localparam int KEY_MSB   = 15;
  localparam int KEY_LSB   = 8;
  localparam int DATA_MSB  = 7;
  localparam int PAR_FIRST = 5;
  localparam int PAR_N     = 3;

  // two-bit fault codes
  localparam logic [1:0] CODE_NONE  = 2'h0;
  localparam logic [1:0] CODE_OPEN  = 2'h1;
  localparam logic [1:0] CODE_SHORT = 2'h2;
  localparam logic [1:0] CODE_OVC   = 2'h3;

  // command keywords in the upper byte of a frame
  localparam logic [7:0] KEY_OUTPUT  = 8'hac;
  localparam logic [7:0] KEY_DIAG    = 8'ha3;
  localparam logic [7:0] KEY_PROTECT = 8'haa;

  // reset values, and the all-ones thermal readout word
  localparam logic [15:0] FAULT_RESET      = 16'h0000;
  localparam logic [15:0] THERMAL_WORD     = 16'hffff;
  localparam logic [7:0]  OUT_CMD_RESET    = 8'h00;
  localparam logic [7:0]  DIAG_LATCH_RESET = 8'h00;
  localparam logic [7:0]  LIN_LIMIT_RESET  = 8'h00;
  localparam logic [2:0]  SPI_SYNC_RESET   = 3'h1;
  localparam logic        CS_IDLE          = 1'b1;

  // timing, in ns and in cycles of the 100 MHz system clock
  localparam int CLK_PERIOD_NS = 10;
  localparam int TDEL_NS       = 10000;
  localparam int TFILT_NS      = 20000;
  localparam int TRES_NS       = 1000000;
  localparam int TDEL_CYC  = (TDEL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TFILT_CYC = (TFILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TRES_CYC  = (TRES_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [3:0] {
    CMD_NONE    = 4'h1,
    CMD_OUTPUT  = 4'h2,
    CMD_DIAG    = 4'h4,
    CMD_PROTECT = 4'h8
  } cmd_kind_t;
endpackage

// [verilog/input_sync.sv]
// three-stage synchroniser that passes a bit once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module input_sync #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } sync_t;

  sync_t st;
  sync_t next_st;

  generate
    if (W < 1) begin : g_bad_width
      $error("input_sync width must be at least one");
    end
  endgenerate

  // shift chain, output follows only agreeing stages
  always_comb begin
    next_st    = st;
    next_st.s1 = d;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    for (int i = 0; i < W; i++) begin
      if (st.s2[i] == st.s3[i]) begin
        next_st.q[i] = st.s2[i];
      end
    end
  end

  // state register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '{s1: RST_VAL, s2: RST_VAL, s3: RST_VAL, q: RST_VAL};
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign q = st.q;
endmodule
`default_nettype wire

// [verilog/frame_port.sv]
// serial frame engine: select and clock edges, shift path, frame length check
`timescale 1ns/1ps
`default_nettype none
module frame_port (
  input  wire logic                            clk,
  input  wire logic                            rst_b,
  input  wire logic                            ce,
  input  wire logic                            cs_b,
  input  wire logic                            sclk,
  input  wire logic                            di,
  input  wire logic [drv_diag_pkg::WORD_W-1:0] load_word,
  output logic                                 cs_falling,
  output logic                                 frame_end,
  output logic                                 frame_whole,
  output logic      [drv_diag_pkg::WORD_W-1:0] word,
  output logic                                 do_bit,
  output logic                                 do_oe
);
  localparam int W  = drv_diag_pkg::WORD_W;
  localparam int BW = $clog2(W);

  typedef struct packed {
    logic          cs_q;
    logic          sclk_q;
    logic          any;
    logic [BW-1:0] bits;
    logic [W-1:0]  sreg;
    logic          do_bit;
  } port_t;

  port_t st;
  port_t next_st;

  // edges seen against the previous sample
  assign cs_falling  = st.cs_q & ~cs_b;
  assign frame_end   = ~st.cs_q & cs_b;
  assign frame_whole = frame_end & st.any & (st.bits == '0);
  assign word        = st.sreg;

  // load on select, shift in on sclk rise, change output on sclk fall
  always_comb begin
    next_st        = st;
    next_st.cs_q   = cs_b;
    next_st.sclk_q = sclk;
    if (cs_falling) begin
      next_st.sreg   = load_word;
      next_st.do_bit = load_word[W-1];
      next_st.bits   = '0;
      next_st.any    = 1'b0;
    end else if (!cs_b && !st.cs_q) begin
      if (sclk && !st.sclk_q) begin
        next_st.sreg = {st.sreg[W-2:0], di};
        next_st.bits = st.bits + BW'(1);
        next_st.any  = 1'b1;
      end
      if (!sclk && st.sclk_q) begin
        next_st.do_bit = st.sreg[W-1];   // RQ24
      end
    end
  end

  // state register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '{cs_q: drv_diag_pkg::CS_IDLE, default: '0};
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign do_bit = st.do_bit;
  assign do_oe  = ~st.cs_q;
endmodule
`default_nettype wire

// [verilog/drv_fault_diag.sv]
// octal driver fault diagnosis: command bits, per-channel fault codes, serial readout
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Functional notes
// RQ1: one sixteen-bit fault register, two bits per channel
// RQ2: channel one at bits one:zero, upward
// RQ3: codes none, open, short, overcurrent
// RQ4: thermal fault reads whole register as ones
// RQ5: first variant clears all on valid frame
// RQ6: second variant clears overcurrent by restart or input
// RQ7: latching chosen per channel by command
// RQ8: overcurrent overwrites; later off faults ignored
// RQ9: off faults when off, overcurrent when on
// RQ10: filtered overcurrent switches off and records code
// RQ11: linear limit mode gives no overcurrent report
// RQ12: automatic restart after restart delay
// RQ13: restart by zero then one output frames
// RQ14: parallel input rise restarts channels six-eight
// RQ15: non-latching low side sampled at select fall
// RQ16: non-latching high side sampled at select fall
// RQ17: latching mode holds faults until cleared
// RQ18: latching off faults need full filter time
// RQ19: master filters codes near parallel falling edges
// RQ20: valid frame: sixteen-bit multiple, known keyword
// RQ21: diag bit one latches, zero default
// RQ22: protect bit zero switches off, one limits
// RQ23: thermal sampled at select fall, not held
// RQ24: register loaded at select fall, msb first
module drv_fault_diag #(
  parameter int VARIANT  = 1,
  parameter int TRES_CYC = drv_diag_pkg::TRES_CYC
) (
  input  wire logic       SYS_CLK,
  input  wire logic       RST_B,
  input  wire logic       CLK_EN,
  input  wire logic       SPI_CS_B,
  input  wire logic       SPI_SCLK,
  input  wire logic       SERIAL_DATA_IN,
  output logic            SPI_DO,
  output logic            SPI_DO_OE,
  input  wire logic [2:0] PARALLEL_CONTROL_INPUT,
  input  wire logic [7:0] CHANNEL_HIGHSIDE,
  input  wire logic [7:0] NODE_ABOVE_UPPER,
  input  wire logic [7:0] NODE_BELOW_LOWER,
  input  wire logic [7:0] OVERCURRENT_SENSE,
  input  wire logic [7:0] THERMAL_FAULT,
  output logic      [7:0] OUTPUT_CHANNEL,
  output logic      [7:0] LINEAR_LIMIT
);
  localparam int NCH = drv_diag_pkg::NCH;
  localparam int NPF = drv_diag_pkg::PAR_FIRST;
  localparam int DW  = $clog2(drv_diag_pkg::TDEL_CYC + 1);
  localparam int FW  = $clog2(drv_diag_pkg::TFILT_CYC + 1);
  localparam int RW  = $clog2(TRES_CYC + 1);
  localparam int NIN = 5 * NCH + drv_diag_pkg::PAR_N;

  generate
    if (VARIANT < 1 || VARIANT > 2 || TRES_CYC < 2) begin : g_bad_param
      $error("VARIANT must be 1 or 2 and TRES_CYC at least 2");
    end
  endgenerate

  typedef struct packed {
    logic [15:0]             fault;
    logic [NCH-1:0]          out_cmd;
    logic [NCH-1:0]          diag_latch;
    logic [NCH-1:0]          lin_limit;
    logic [NCH-1:0]          ovc_off;
    logic [NCH-1:0]          prev_zero;
    logic [NCH-1:0]          gate;
    logic [2:0]              par_q;
    logic [NCH-1:0][DW-1:0]  del_cnt;
    logic [NCH-1:0][FW-1:0]  filt_cnt;
    logic [NCH-1:0][RW-1:0]  res_cnt;
  } diag_t;

  diag_t                   st;
  diag_t                   next_st;
  logic [2:0]              spi_s;
  logic [NIN-1:0]          pin_s;
  logic [NCH-1:0]          hs;
  logic [NCH-1:0]          above;
  logic [NCH-1:0]          below;
  logic [NCH-1:0]          oc;
  logic [NCH-1:0]          therm;
  logic [2:0]              par_s;
  logic [NCH-1:0]          par_vec;
  logic [NCH-1:0]          par_old;
  logic [NCH-1:0]          ch_on;
  logic                    cs_falling;
  logic                    frame_end;
  logic                    frame_whole;
  logic [15:0]             word;
  logic [15:0]             load_word;
  logic                    frame_ok;
  drv_diag_pkg::cmd_kind_t kind;
  logic [NCH-1:0]          trip;
  logic [NCH-1:0][1:0]     samp_v;

  // keyword decode of a received frame
  function automatic drv_diag_pkg::cmd_kind_t key_kind(input logic [7:0] k);
    case (k)
      drv_diag_pkg::KEY_OUTPUT:  return drv_diag_pkg::CMD_OUTPUT;
      drv_diag_pkg::KEY_DIAG:    return drv_diag_pkg::CMD_DIAG;
      drv_diag_pkg::KEY_PROTECT: return drv_diag_pkg::CMD_PROTECT;
      default:                   return drv_diag_pkg::CMD_NONE;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  input_sync #(
    .W       (3),
    .RST_VAL (drv_diag_pkg::SPI_SYNC_RESET)
  ) u_spi_sync (
    .clk   (SYS_CLK),
    .rst_b (RST_B),
    .ce    (CLK_EN),
    .d     ({SERIAL_DATA_IN, SPI_SCLK, SPI_CS_B}),
    .q     (spi_s)
  );

  input_sync #(
    .W       (NIN),
    .RST_VAL ('0)
  ) u_pin_sync (
    .clk   (SYS_CLK),
    .rst_b (RST_B),
    .ce    (CLK_EN),
    .d     ({PARALLEL_CONTROL_INPUT, THERMAL_FAULT, OVERCURRENT_SENSE,
             NODE_BELOW_LOWER, NODE_ABOVE_UPPER, CHANNEL_HIGHSIDE}),
    .q     (pin_s)
  );

  // unpack synchronised comparator and control levels
  assign hs      = pin_s[0 +: NCH];
  assign above   = pin_s[NCH +: NCH];
  assign below   = pin_s[2*NCH +: NCH];
  assign oc      = pin_s[3*NCH +: NCH];
  assign therm   = pin_s[4*NCH +: NCH];
  assign par_s   = pin_s[5*NCH +: 3];
  assign par_vec = {par_s, {NPF{1'b0}}};
  assign par_old = {st.par_q, {NPF{1'b0}}};
  assign ch_on   = st.out_cmd | par_vec;

  ////////////////////////////////////////////////////////////////////////////
  // serial frame engine
  frame_port u_frame (
    .clk         (SYS_CLK),
    .rst_b       (RST_B),
    .ce          (CLK_EN),
    .cs_b        (spi_s[0]),
    .sclk        (spi_s[1]),
    .di          (spi_s[2]),
    .load_word   (load_word),
    .cs_falling  (cs_falling),
    .frame_end   (frame_end),
    .frame_whole (frame_whole),
    .word        (word),
    .do_bit      (SPI_DO),
    .do_oe       (SPI_DO_OE)
  );

  ////////////////////////////////////////////////////////////////////////////
  // command decode and per-channel fault logic
  always_comb begin
    logic [1:0] c;
    logic       oc_run;
    c        = drv_diag_pkg::CODE_NONE;
    oc_run   = 1'b0;
    next_st  = st;
    trip     = '0;
    samp_v   = '0;
    kind     = key_kind(word[drv_diag_pkg::KEY_MSB:drv_diag_pkg::KEY_LSB]);
    frame_ok = frame_whole && kind != drv_diag_pkg::CMD_NONE;   // RQ20
    next_st.par_q = par_s;
    if (frame_ok) begin
      next_st.prev_zero = '0;
      case (kind)
        drv_diag_pkg::CMD_OUTPUT: begin
          next_st.out_cmd   = word[NCH-1:0];
          next_st.prev_zero = ~word[NCH-1:0];   // RQ13
        end
        drv_diag_pkg::CMD_DIAG: begin
          next_st.diag_latch = word[NCH-1:0];   // RQ7
        end
        drv_diag_pkg::CMD_PROTECT: begin
          next_st.lin_limit = word[NCH-1:0];    // RQ22
        end
        default: begin
          next_st.prev_zero = '0;
        end
      endcase
    end
    for (int i = 0; i < NCH; i++) begin
      c = st.fault[2*i +: 2];   // RQ1
      // classify the node comparators
      if (hs[i] ? above[i] : below[i]) begin
        samp_v[i] = drv_diag_pkg::CODE_SHORT;   // RQ3
      end else if (!above[i] && !below[i]) begin
        samp_v[i] = drv_diag_pkg::CODE_OPEN;
      end
      // valid frame clear, before any new set so the set wins
      if (frame_ok && (VARIANT == 1 || c != drv_diag_pkg::CODE_OVC)) begin
        c = drv_diag_pkg::CODE_NONE;   // RQ5
      end
      // restart by command pair and by parallel input rise
      if (frame_ok && kind == drv_diag_pkg::CMD_OUTPUT && st.prev_zero[i] && word[i]) begin
        next_st.ovc_off[i] = 1'b0;   // RQ13
      end
      if (par_vec[i] && !par_old[i]) begin
        next_st.ovc_off[i] = 1'b0;   // RQ14
      end
      if (VARIANT == 2 && i >= NPF && !par_vec[i] && c == drv_diag_pkg::CODE_OVC) begin
        c = drv_diag_pkg::CODE_NONE;   // RQ6
      end
      // restart delay after a shutdown
      if (st.ovc_off[i]) begin
        if (st.res_cnt[i] == RW'(TRES_CYC - 1)) begin
          next_st.ovc_off[i] = 1'b0;   // RQ12
          next_st.res_cnt[i] = '0;
          if (VARIANT == 2 && c == drv_diag_pkg::CODE_OVC) begin
            c = drv_diag_pkg::CODE_NONE;   // RQ6
          end
        end else begin
          next_st.res_cnt[i] = st.res_cnt[i] + RW'(1);
        end
      end else begin
        next_st.res_cnt[i] = '0;
      end
      // on-state overcurrent filter
      oc_run = ch_on[i] && !st.ovc_off[i] && !st.lin_limit[i] && oc[i];   // RQ9 RQ11
      trip[i] = oc_run && st.del_cnt[i] == DW'(drv_diag_pkg::TDEL_CYC - 1);
      next_st.del_cnt[i] = (oc_run && !trip[i]) ? st.del_cnt[i] + DW'(1) : '0;
      if (trip[i]) begin
        next_st.ovc_off[i] = 1'b1;   // RQ10
        c = drv_diag_pkg::CODE_OVC;   // RQ8
      end
      // off-state open load and short diagnosis
      if (!ch_on[i] && c != drv_diag_pkg::CODE_OVC) begin   // RQ9 RQ8
        if (st.diag_latch[i]) begin
          if (samp_v[i] == drv_diag_pkg::CODE_NONE) begin
            next_st.filt_cnt[i] = '0;
          end else if (st.filt_cnt[i] == FW'(drv_diag_pkg::TFILT_CYC - 1)) begin
            c = samp_v[i];   // RQ18 RQ17
          end else begin
            next_st.filt_cnt[i] = st.filt_cnt[i] + FW'(1);
          end
        end else begin
          next_st.filt_cnt[i] = '0;
          if (cs_falling) begin
            c = samp_v[i];   // RQ15 RQ16
          end
        end
      end else begin
        next_st.filt_cnt[i] = '0;
      end
      // follow the command of the frame that ends now, so a restart pair turns on at once
      next_st.gate[i]        = (next_st.out_cmd[i] | par_vec[i]) & ~next_st.ovc_off[i];   // RQ13
      next_st.fault[2*i +: 2] = c;   // RQ2
    end
    // readout word: thermal overrides, sampled live
    load_word = (|therm) ? drv_diag_pkg::THERMAL_WORD : next_st.fault;   // RQ4 RQ23 RQ24
  end

  // state register
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      st <= '{fault:      drv_diag_pkg::FAULT_RESET,
              out_cmd:    drv_diag_pkg::OUT_CMD_RESET,
              diag_latch: drv_diag_pkg::DIAG_LATCH_RESET,   // RQ21
              lin_limit:  drv_diag_pkg::LIN_LIMIT_RESET,
              default:    '0};
    end else if (CLK_EN) begin
      st <= next_st;
    end
  end

  assign OUTPUT_CHANNEL = st.gate;
  assign LINEAR_LIMIT   = st.lin_limit;

  ////////////////////////////////////////////////////////////////////////////
  // checks on channel one, plus whole-register thermal word and valid-frame clear
  logic [1:0]    fault0;
  logic [FW-1:0] filt0;
  assign fault0 = st.fault[1:0];
  assign filt0  = st.filt_cnt[0];

  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RST_B);

  property p_thermal_ones;
    cs_falling && (|therm) |-> load_word == drv_diag_pkg::THERMAL_WORD;
  endproperty
  a_thermal_ones: assert property (p_thermal_ones) else $error("thermal word not ones"); // RQ4

  property p_ovc_held;
    VARIANT == 1 && CLK_EN && fault0 == drv_diag_pkg::CODE_OVC && !frame_ok
      |=> fault0 == drv_diag_pkg::CODE_OVC;
  endproperty
  a_ovc_held: assert property (p_ovc_held) else $error("overcurrent code lost"); // RQ8

  property p_trip_off;
    CLK_EN && trip[0] |=> !OUTPUT_CHANNEL[0] && fault0 == drv_diag_pkg::CODE_OVC;
  endproperty
  a_trip_off: assert property (p_trip_off) else $error("trip did not shut off"); // RQ10

  property p_off_only;
    CLK_EN && fault0 == drv_diag_pkg::CODE_NONE ##1
      (fault0 == drv_diag_pkg::CODE_OPEN || fault0 == drv_diag_pkg::CODE_SHORT)
      |-> $past(ch_on) == 8'h00 || !$past(ch_on[0]);
  endproperty
  a_off_only: assert property (p_off_only) else $error("off fault while on"); // RQ9

  property p_linear;
    CLK_EN && st.lin_limit[0] && !st.ovc_off[0] |=> !st.ovc_off[0];
  endproperty
  a_linear: assert property (p_linear) else $error("shutdown in linear mode"); // RQ11

  property p_auto_restart;
    CLK_EN && st.ovc_off[0] && st.res_cnt[0] == RW'(TRES_CYC - 1) |=> !st.ovc_off[0];
  endproperty
  a_auto_restart: assert property (p_auto_restart) else $error("no restart"); // RQ12

  property p_frame_restart;
    CLK_EN && frame_ok && kind == drv_diag_pkg::CMD_OUTPUT && st.prev_zero[0]
      && word[0] && st.ovc_off[0] |=> OUTPUT_CHANNEL[0];
  endproperty
  a_frame_restart: assert property (p_frame_restart) else $error("frame restart"); // RQ13

  property p_valid_clear;
    VARIANT == 1 && CLK_EN && frame_ok && trip == 8'h00 && st.diag_latch == 8'h00
      |=> st.fault == drv_diag_pkg::FAULT_RESET;
  endproperty
  a_valid_clear: assert property (p_valid_clear) else $error("fault not cleared"); // RQ5

  property p_filter;
    CLK_EN && st.diag_latch[0] && !frame_ok && fault0 == drv_diag_pkg::CODE_NONE ##1
      (fault0 == drv_diag_pkg::CODE_OPEN || fault0 == drv_diag_pkg::CODE_SHORT)
      |-> $past(filt0) == FW'(drv_diag_pkg::TFILT_CYC - 1);
  endproperty
  a_filter: assert property (p_filter) else $error("latched before filter time"); // RQ18

  property p_nolatch_sample;
    cs_falling && !st.diag_latch[0] && !ch_on[0] && !(|therm) && !trip[0]
      && fault0 != drv_diag_pkg::CODE_OVC |-> load_word[1:0] == samp_v[0];
  endproperty
  a_nolatch_sample: assert property (p_nolatch_sample) else $error("bad sample"); // RQ15

  c_trip:    cover property (CLK_EN && trip[0]);
  c_thermal: cover property (cs_falling && (|therm));
  c_restart: cover property (CLK_EN && frame_ok && st.prev_zero[0] && word[0] && st.ovc_off[0]);
  c_latch:   cover property (CLK_EN && st.diag_latch[0] && filt0 == FW'(drv_diag_pkg::TFILT_CYC - 1));
endmodule
`default_nettype wire

// [dv/spi_master_model.sv]
// serial master model that frames commands and collects the fault word
`timescale 1ns/1ps
`default_nettype none
module spi_master_model (
  input  wire logic clk,
  output logic      cs_b,
  output logic      sclk,
  output logic      di,
  input  wire logic do_in
);
  // idle select high, clock low, data parked
  initial begin
    cs_b = 1'b1;
    sclk = 1'b0;
    di   = 1'b0;
  end

  // wait a number of system clock edges
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // one frame of nbits, msb first; rd keeps the last sixteen bits seen
  task automatic xfer(input logic [15:0] cmd, input int nbits, output logic [15:0] rd);
    rd = 16'h0000;
    @(posedge clk);
    cs_b <= 1'b0;
    tick(8);
    for (int i = nbits - 1; i >= 0; i--) begin
      di <= cmd[i];
      tick(8);
      rd = {rd[14:0], do_in};
      sclk <= 1'b1;
      tick(8);
      sclk <= 1'b0;
    end
    tick(8);
    cs_b <= 1'b1;
    di   <= ~di; // released data line shows the inverse
    tick(12);
  endtask
endmodule
`default_nettype wire

// [dv/drv_fault_diag_tb_top.sv]
// self-checking bench for the octal driver fault diagnosis block
`timescale 1ns/1ps
`default_nettype none
module drv_fault_diag_tb_top;
  localparam int TRES = 2000;
  logic        sys_clk = 1'b0;
  logic        rst_b   = 1'b0;
  logic        clk_en  = 1'b1;
  logic [2:0]  par_in, p;
  logic [7:0]  hs, above, below, overcurrent_indication, therm, a, b, d;
  logic        cs_b, sclk, di, do_bit, do_oe;
  logic [7:0]  out_ch, lin;
  logic [15:0] rd;
  int          err_count   = 0;
  int          check_count = 0;
  int          seed        = 79;
  int          n;

  ////////////////////////////////////////////////////////////////////////////////
  // clock, design and far-side master
  always #5 sys_clk = ~sys_clk;

  drv_fault_diag #(.VARIANT(1), .TRES_CYC(TRES)) dut (
    .SYS_CLK(sys_clk), .RST_B(rst_b), .CLK_EN(clk_en), .SPI_CS_B(cs_b),
    .SPI_SCLK(sclk), .SERIAL_DATA_IN(di), .SPI_DO(do_bit), .SPI_DO_OE(do_oe),
    .PARALLEL_CONTROL_INPUT(par_in), .CHANNEL_HIGHSIDE(hs), .NODE_ABOVE_UPPER(above),
    .NODE_BELOW_LOWER(below), .OVERCURRENT_SENSE(overcurrent_indication), .THERMAL_FAULT(therm),
    .OUTPUT_CHANNEL(out_ch), .LINEAR_LIMIT(lin));

  spi_master_model m (.clk(sys_clk), .cs_b(cs_b), .sclk(sclk), .di(di), .do_in(do_bit));

  ////////////////////////////////////////////////////////////////////////////////
  // checking helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] want, input string what);
    check_count++;
    if (got !== want) begin
      err_count++;
      $display("[ERR] %0t %s got %h want %h", $time, what, got, want);
    end
  endtask

  task automatic close_out();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic send(input logic [7:0] key, input logic [7:0] data);
    m.xfer({key, data}, 16, rd);
  endtask

  // expected off-state codes of channels in no-latch mode
  function automatic logic [15:0] exp_word(input logic [7:0] h, input logic [7:0] ab,
                                           input logic [7:0] be);
    logic [15:0] w;
    for (int i = 0; i < 8; i++) begin
      if (h[i] ? ab[i] : be[i]) w[2*i+:2] = drv_diag_pkg::CODE_SHORT;
      else if (h[i] ? be[i] : ab[i]) w[2*i+:2] = drv_diag_pkg::CODE_NONE;
      else w[2*i+:2] = drv_diag_pkg::CODE_OPEN;
    end
    return w;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // watchdog against a hang
  initial begin
    repeat (60000) @(posedge sys_clk);
    err_count++;
    $display("[ERR] %0t watchdog expired", $time);
    close_out();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    par_in = 3'h0;
    hs     = 8'h00;
    above  = 8'h00;
    below  = 8'h00;
    overcurrent_indication    = 8'h00;
    therm  = 8'h00;
    repeat (3) @(posedge sys_clk);
    chk({out_ch, lin}, 16'h0000, "reset outputs");
    @(posedge sys_clk);
    rst_b <= 1'b1;
    m.tick(8);
    // no-latch off codes, corner of all shorted first
    for (int k = 0; k < 6; k++) begin
      a = (k == 0) ? 8'hff : 8'($random(seed));
      b = 8'($random(seed)) & ~a;
      hs    <= (k == 0) ? 8'hff : 8'($random(seed));
      above <= a;
      below <= b;
      m.tick(10);
      send(drv_diag_pkg::KEY_OUTPUT, 8'h00);
      chk(rd, exp_word(hs, above, below), "no-latch codes");
    end
    // thermal reads as all ones, only while present
    therm <= 8'h01 << (8'($random(seed)) & 8'h07);
    m.tick(10);
    send(drv_diag_pkg::KEY_OUTPUT, 8'h00);
    chk(rd, drv_diag_pkg::THERMAL_WORD, "thermal word");
    therm <= 8'h00;
    m.tick(10);
    send(drv_diag_pkg::KEY_OUTPUT, 8'h00);
    chk(rd, exp_word(hs, above, below), "thermal gone");
    // output and protect commands, short frame and bad key refused
    for (int k = 0; k < 3; k++) begin
      d = 8'($random(seed));
      send(drv_diag_pkg::KEY_OUTPUT, d);
      m.tick(8);
      chk({8'h00, out_ch}, {8'h00, d}, "output command");
      m.xfer({drv_diag_pkg::KEY_OUTPUT, ~d}, 12, rd);
      send(8'h55, ~d);
      m.tick(8);
      chk({8'h00, out_ch}, {8'h00, d}, "refused frame");
      send(drv_diag_pkg::KEY_PROTECT, d);
      m.tick(8);
      chk({8'h00, lin}, {8'h00, d}, "protect bits");
    end
    // mid-run reset returns command bits to defaults
    rst_b <= 1'b0;
    m.tick(2);
    chk({out_ch, lin}, 16'h0000, "mid-run reset");
    rst_b <= 1'b1;
    m.tick(8);
    send(drv_diag_pkg::KEY_PROTECT, 8'h00);
    // overcurrent trip on channel one and automatic restart
    send(drv_diag_pkg::KEY_OUTPUT, 8'h01);
    overcurrent_indication <= 8'($random(seed)) | 8'h01;
    n = 0;
    while (out_ch[0] !== 1'b0 && n < 1100) begin
      @(posedge sys_clk);
      n++;
    end
    chk(16'(n >= drv_diag_pkg::TDEL_CYC && n < 1100), 16'h0001, "trip time");
    overcurrent_indication <= 8'h00;
    n = 0;
    while (out_ch[0] !== 1'b1 && n < TRES + 20) begin
      @(posedge sys_clk);
      n++;
    end
    chk(16'(n >= TRES - 2 && n < TRES + 20), 16'h0001, "restart time");
    send(drv_diag_pkg::KEY_OUTPUT, 8'h01);
    chk({14'h0, rd[1:0]}, {14'h0, drv_diag_pkg::CODE_OVC}, "overcurrent code");
    send(drv_diag_pkg::KEY_OUTPUT, 8'h01);
    chk({14'h0, rd[1:0]}, 16'h0000, "cleared after frame");
    // second trip, restart by a zero then one output frame pair
    overcurrent_indication <= 8'h01;
    m.tick(1010);
    overcurrent_indication <= 8'h00;
    chk({15'h0, out_ch[0]}, 16'h0000, "tripped again");
    send(drv_diag_pkg::KEY_OUTPUT, 8'h00);
    send(drv_diag_pkg::KEY_OUTPUT, 8'h01);
    chk({15'h0, out_ch[0]}, 16'h0001, "frame restart");
    // linear limit keeps channel on with no report
    send(drv_diag_pkg::KEY_PROTECT, 8'h01);
    overcurrent_indication <= 8'h01;
    m.tick(1200);
    chk({15'h0, out_ch[0]}, 16'h0001, "limited stays on");
    send(drv_diag_pkg::KEY_OUTPUT, 8'h01);
    chk({14'h0, rd[1:0]}, 16'h0000, "no limit report");
    overcurrent_indication <= 8'h00;
    send(drv_diag_pkg::KEY_PROTECT, 8'h00);
    send(drv_diag_pkg::KEY_OUTPUT, 8'h00);
    // latching channels one and two: short filter, then hold until cleared
    send(drv_diag_pkg::KEY_DIAG, 8'h03);
    hs    <= 8'h00;
    above <= 8'hff;
    below <= 8'h00;
    m.tick(10);
    below <= 8'h03;
    m.tick(1000);
    below <= 8'h00;
    m.tick(10);
    send(drv_diag_pkg::KEY_DIAG, 8'h03);
    chk(rd, 16'h0000, "short too brief");
    below <= 8'h03;
    m.tick(drv_diag_pkg::TFILT_CYC + 20);
    below <= 8'h00;
    m.tick(10);
    send(drv_diag_pkg::KEY_DIAG, 8'h03);
    chk(rd, 16'h000a, "latched short");
    send(drv_diag_pkg::KEY_DIAG, 8'h00);
    chk(rd, 16'h0000, "latched cleared");
    // enable low freezes the parallel path, then inputs drive channels six-eight
    p = 3'($random(seed)) | 3'h1;
    clk_en <= 1'b0;
    par_in <= p;
    m.tick(10);
    chk({8'h00, out_ch}, 16'h0000, "frozen by enable");
    clk_en <= 1'b1;
    m.tick(10);
    chk({8'h00, out_ch}, {8'h00, p, 5'h00}, "parallel on");
    // overcurrent on parallel channels, restart by input rise
    overcurrent_indication <= 8'he0;
    m.tick(1010);
    chk({8'h00, out_ch}, 16'h0000, "parallel trip");
    overcurrent_indication    <= 8'h00;
    par_in <= 3'h0;
    m.tick(10);
    par_in <= p;
    m.tick(10);
    chk({8'h00, out_ch}, {8'h00, p, 5'h00}, "parallel restart");
    par_in <= 3'h0;
    m.tick(10);
    close_out();
  end
endmodule
`default_nettype wire
